// ==== src/rtc_pkg.sv ====
// shared register map, field positions, reset values and types of the rtc register block
// assumes byte-wide registers behind a 5-bit auto-incrementing pointer
package rtc_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int REG_COUNT = 18;
	localparam int TIME_COUNT = 7;

	localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 5'h01;
	localparam logic [ADDR_W-1:0] ADDR_TRIM = 5'h02;
	localparam logic [ADDR_W-1:0] ADDR_SCRATCH = 5'h03;
	localparam logic [ADDR_W-1:0] ADDR_SECONDS = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_YEARS = 5'h0a;
	localparam logic [ADDR_W-1:0] ADDR_ALARM_FIRST = 5'h0b;
	localparam logic [ADDR_W-1:0] ADDR_ALARM_LAST = 5'h0f;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_VALUE = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_MODE = 5'h11;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 5'h11;
	localparam logic [ADDR_W-1:0] ADDR_FIRST = 5'h00;

	// time counter slots, counted from the seconds register
	localparam int T_SEC = 0;
	localparam int T_MIN = 1;
	localparam int T_HOUR = 2;
	localparam int T_DAY = 3;
	localparam int T_WDAY = 4;
	localparam int T_MON = 5;
	localparam int T_YEAR = 6;

	localparam int CMD_READ_BIT = 7;
	localparam int STOP_BIT = 5;
	localparam int MODE_12H_BIT = 1;
	localparam int COF_LSB = 0;
	localparam int COF_W = 3;
	localparam int OS_BIT = 7;
	localparam int AMPM_BIT = 5;

	localparam logic [7:0] BCD_00 = 8'h00;
	localparam logic [7:0] BCD_01 = 8'h01;
	localparam logic [7:0] BCD_06 = 8'h06;
	localparam logic [7:0] BCD_11 = 8'h11;
	localparam logic [7:0] BCD_12 = 8'h12;
	localparam logic [7:0] BCD_23 = 8'h23;
	localparam logic [7:0] BCD_28 = 8'h28;
	localparam logic [7:0] BCD_29 = 8'h29;
	localparam logic [7:0] BCD_30 = 8'h30;
	localparam logic [7:0] BCD_31 = 8'h31;
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] BCD_99 = 8'h99;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] MON_FEB = 8'h02;
	localparam logic [7:0] MON_APR = 8'h04;
	localparam logic [7:0] MON_JUN = 8'h06;
	localparam logic [7:0] MON_SEP = 8'h09;
	localparam logic [7:0] MON_NOV = 8'h11;
	localparam logic [7:0] HOUR12_MASK = 8'h1f;

	// implemented bits per address; unimplemented bits store nothing and read zero
	localparam logic [7:0] REG_MASK [REG_COUNT] = '{
		8'hb7, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h3f, 8'h3f, 8'h07,
		8'h1f, 8'hff, 8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'hff, 8'h1f};
	localparam logic [7:0] REG_RESET [REG_COUNT] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h06,
		8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};

	// clock output select: 0 crystal, 1..5 halvings down to 1.024 khz, 6 one hertz, 7 off
	localparam int CLOCK_OUTPUT_TAPS = 8;
	localparam int TAP_1KHZ_BIT = 4;

	localparam int PIN_XTAL = 0;
	localparam int PIN_CLOCK_OUTPUT_ENABLE = 1;
	localparam int PIN_CE = 2;
	localparam int PIN_SCL = 3;
	localparam int PIN_SDIO = 4;
	localparam int PIN_COUNT = 5;

	localparam int CLK_PERIOD_NS = 20;
	// four crystal periods without an edge count as a stopped oscillator
	localparam int XTAL_STOP_NS = 122070;
	localparam int XTAL_STOP_CYCLES_DEF = (XTAL_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRESCALE_BITS_DEF = 15;

	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} wr_req_t;

	typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_DATA} ser_state_t;
endpackage

// ==== src/reg_bank.sv ====
// byte store for the non-counter registers, registered read port
// assumes the caller never writes the time counter slots here
`timescale 1ns/1ps
module reg_bank
	import rtc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire wr_req_t wr,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data_r,
	output logic [DATA_W-1:0] ctrl_one,
	output logic [DATA_W-1:0] ctrl_two
);
	logic [DATA_W-1:0] mem_r [REG_COUNT];

	for (genvar i = 0; i < REG_COUNT; i++) begin : g_entry
		wire hit = wr.en && (wr.addr == ADDR_W'(i));
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				mem_r[i] <= REG_RESET[i];
			end else if (hit) begin
				mem_r[i] <= wr.data & REG_MASK[i];
			end
		end
	end

	wire rd_valid = rd_addr <= ADDR_LAST;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_r <= '0;
		end else begin
			rd_data_r <= rd_valid ? mem_r[rd_addr] : '0;
		end
	end

	assign ctrl_one = mem_r[ADDR_CTRL_ONE];
	assign ctrl_two = mem_r[ADDR_CTRL_TWO];
endmodule // reg_bank

// ==== src/rtc_register_access.sv ====
// rtc register access: 3-wire serial slave, register map, bcd time counters, clock output
// assumes all pins are asynchronous to clk and the crystal pin carries a 32.768 khz square wave
//
// Operation
// [R1] pointer advances after every data byte
// [R2] pointer wraps from 11h to 00h
// [R3] eighteen byte registers behind one pointer
// [R4] unimplemented bits store nothing, read zero
// [R5] control registers at 00h and 01h
// [R6] trim at 02h, scratch byte at 03h
// [R7] time counters at 04h through 0Ah
// [R8] alarm registers at 0Bh through 0Fh
// [R9] timer registers at 10h and 11h
// [R10] time and alarm values in bcd
// [R11] counters frozen during serial access
// [R12] seconds derived by dividing crystal clock
// [R13] clock output selectable, crystal down to 1 Hz
// [R14] clock output only while enable pin high
// [R15] chip enable, serial clock, shared data line
// [R16] host keeps bit rate within limit
// [R17] host frames each transaction with chip enable
// [R18] defaults loaded before serial access accepted
`timescale 1ns/1ps
module rtc_register_access
	import rtc_pkg::*;
#(
	parameter int PRESCALE_BITS = PRESCALE_BITS_DEF,
	parameter int XTAL_STOP_CYCLES = XTAL_STOP_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic crystal_in,
	output logic crystal_out,
	input wire logic clock_output_enable,
	output logic clock_output,
	input wire logic ce,
	input wire logic scl,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe
);
	// pin synchronisers; only the second stage is read
	wire [PIN_COUNT-1:0] pins_raw = {sdio_in, scl, ce, clock_output_enable, crystal_in};
	logic [PIN_COUNT-1:0] sync1_r;
	logic [PIN_COUNT-1:0] sync2_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
		end
	end

	wire xtal_s = sync2_r[PIN_XTAL];
	wire clock_output_enable_s = sync2_r[PIN_CLOCK_OUTPUT_ENABLE];
	wire ce_s = sync2_r[PIN_CE]; // see [R15]
	wire scl_s = sync2_r[PIN_SCL];
	wire sdio_s = sync2_r[PIN_SDIO];

	logic xtal_d_r;
	logic scl_d_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			xtal_d_r <= 1'b0;
			scl_d_r <= 1'b0;
		end else begin
			xtal_d_r <= xtal_s;
			scl_d_r <= scl_s;
		end
	end

	wire xtal_rise = xtal_s & ~xtal_d_r;
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;

	// held off for one cycle after reset so the defaults are in place first
	logic ready_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= 1'b1; // see [R18]
		end
	end

	// register file for everything except the time counters
	logic [DATA_W-1:0] ctrl_one;
	logic [DATA_W-1:0] ctrl_two;
	logic [DATA_W-1:0] mem_rd_data;
	logic [ADDR_W-1:0] addr_r;
	wr_req_t wr_req;
	wr_req_t mem_wr;
	logic [7:0] tm_r [TIME_COUNT];

	wire addr_is_time = (addr_r >= ADDR_SECONDS) && (addr_r <= ADDR_YEARS); // see [R7]
	wire [2:0] tidx = 3'(addr_r - ADDR_SECONDS);
	wire stop_s = ctrl_one[STOP_BIT];
	wire mode_12h = ctrl_one[MODE_12H_BIT];
	wire [COF_W-1:0] cof = ctrl_two[COF_LSB +: COF_W];

	// time slots are never written into the bank, so they read back only from here
	assign mem_wr.en = wr_req.en && !addr_is_time;
	assign mem_wr.addr = wr_req.addr;
	assign mem_wr.data = wr_req.data;

	reg_bank u_bank (
		.clk(clk),
		.rstn(rstn),
		.wr(mem_wr),
		.rd_addr(addr_r),
		.rd_data_r(mem_rd_data),
		.ctrl_one(ctrl_one),
		.ctrl_two(ctrl_two)
	); // see [R3] [R5] [R6] [R8] [R9]

	// crystal divider: bit k toggles at 32.768 khz / 2^(k+1)
	logic [PRESCALE_BITS-1:0] div_r;
	wire sec_wr = wr_req.en && (wr_req.addr == ADDR_SECONDS);
	wire second_tick = xtal_rise && (&div_r) && !stop_s;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_r <= '0;
		end else if (stop_s || sec_wr) begin
			div_r <= '0; // a written second then lasts a full second
		end else if (xtal_rise) begin
			div_r <= div_r + 1'b1; // see [R12]
		end
	end

	logic xo_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			xo_r <= 1'b0;
		end else begin
			xo_r <= ~xtal_s;
		end
	end
	assign crystal_out = xo_r;

	// clock output tap selection
	wire [CLOCK_OUTPUT_TAPS-1:0] taps = {1'b0, div_r[PRESCALE_BITS-1], div_r[TAP_1KHZ_BIT:0], xtal_s};
	logic clock_output_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clock_output_r <= 1'b0;
		end else begin
			clock_output_r <= clock_output_enable_s & taps[cof]; // see [R13] [R14]
		end
	end
	assign clock_output = clock_output_r;

	// serial slave, mode 0: sample on scl rise, shift out on scl fall
	ser_state_t state_r;
	logic [2:0] bit_cnt_r;
	logic [DATA_W-1:0] rx_r;
	logic [DATA_W-1:0] tx_r;
	logic rd_mode_r;
	logic oe_r;

	wire [DATA_W-1:0] rx_byte = {rx_r[DATA_W-2:0], sdio_s};
	wire byte_done = scl_rise && (bit_cnt_r == 3'h7);
	wire [ADDR_W-1:0] addr_next = (addr_r >= ADDR_LAST) ? ADDR_FIRST : addr_r + 1'b1; // see [R2]
	wire [DATA_W-1:0] time_rd = addr_is_time ? tm_r[tidx] : mem_rd_data;
	wire active = ce_s && ready_r;

	assign wr_req.en = (state_r == SER_DATA) && byte_done && !rd_mode_r && active;
	assign wr_req.addr = addr_r;
	assign wr_req.data = rx_byte & REG_MASK[addr_r <= ADDR_LAST ? addr_r : ADDR_FIRST]; // see [R4]

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= SER_IDLE;
			bit_cnt_r <= '0;
			rx_r <= '0;
			rd_mode_r <= 1'b0;
			addr_r <= ADDR_FIRST;
		end else if (!active) begin
			state_r <= SER_IDLE; // see [R17]
			bit_cnt_r <= '0;
		end else begin
			case (state_r)
				SER_IDLE: begin
					state_r <= SER_CMD;
					bit_cnt_r <= '0;
				end
				SER_CMD: begin
					if (scl_rise) begin
						rx_r <= rx_byte;
						bit_cnt_r <= bit_cnt_r + 1'b1;
					end
					if (byte_done) begin
						rd_mode_r <= rx_byte[CMD_READ_BIT];
						addr_r <= rx_byte[ADDR_W-1:0];
						state_r <= SER_DATA;
					end
				end
				SER_DATA: begin
					if (scl_rise) begin
						rx_r <= rx_byte;
						bit_cnt_r <= bit_cnt_r + 1'b1;
					end
					if (byte_done) begin
						addr_r <= addr_next; // see [R1]
					end
				end
				default: begin
					state_r <= SER_IDLE;
				end
			endcase
		end
	end

	// the read byte is loaded on the fall that opens each data byte
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_r <= '0;
			oe_r <= 1'b0;
		end else begin
			oe_r <= active && (state_r == SER_DATA) && rd_mode_r;
			if (active && (state_r == SER_DATA) && rd_mode_r && scl_fall) begin
				tx_r <= (bit_cnt_r == 3'h0) ? time_rd : {tx_r[DATA_W-2:0], 1'b0};
			end
		end
	end
	assign sdio_out = tx_r[DATA_W-1];
	assign sdio_oe = oe_r; // see [R15]

	// freeze: a second that falls inside an access is held and applied at release
	wire freeze = state_r != SER_IDLE;
	logic pending_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pending_r <= 1'b0;
		end else if (freeze) begin
			pending_r <= pending_r | second_tick; // see [R11]
		end else begin
			pending_r <= pending_r & second_tick;
		end
	end
	wire tick_apply = !freeze && (pending_r || second_tick); // see [R11]

	// oscillator stop watch: sets the flag in the seconds register
	logic [$clog2(XTAL_STOP_CYCLES+1)-1:0] idle_cnt_r;
	wire xtal_stopped = idle_cnt_r == ($bits(idle_cnt_r))'(XTAL_STOP_CYCLES);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_cnt_r <= '0;
		end else if (xtal_rise) begin
			idle_cnt_r <= '0;
		end else if (!xtal_stopped) begin
			idle_cnt_r <= idle_cnt_r + 1'b1;
		end
	end

	// bcd counters
	function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
		input logic [7:0] low);
		logic [7:0] r;
		r = low;
		if (v < top) begin
			if (v[3:0] >= BCD_DIGIT_MAX) begin
				r = {v[7:4] + 4'h1, 4'h0};
			end else begin
				r = {v[7:4], v[3:0] + 4'h1};
			end
		end
		return r;
	endfunction

	// leap year from bcd digits: tens even with units 0/4/8, tens odd with units 2/6
	function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		logic [7:0] d;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		d = BCD_31;
		if (mon == MON_FEB) begin
			d = leap ? BCD_29 : BCD_28;
		end else if (mon == MON_APR || mon == MON_JUN || mon == MON_SEP || mon == MON_NOV) begin
			d = BCD_30;
		end
		return d;
	endfunction

	logic [7:0] tm_nxt [TIME_COUNT];
	logic [7:0] val [TIME_COUNT];
	logic [7:0] top [TIME_COUNT];
	logic [7:0] low [TIME_COUNT];
	logic [TIME_COUNT-1:0] wrap;
	logic [TIME_COUNT-1:0] inc;

	for (genvar i = 0; i < TIME_COUNT; i++) begin : g_val
		assign val[i] = tm_r[i] & REG_MASK[i + ADDR_SECONDS];
	end

	wire [7:0] hour12 = tm_r[T_HOUR] & HOUR12_MASK;
	wire pm = tm_r[T_HOUR][AMPM_BIT];

	assign top = '{BCD_59, BCD_59, BCD_23,
		days_in_month(val[T_MON], val[T_YEAR]), BCD_06, BCD_12, BCD_99};
	assign low = '{BCD_00, BCD_00, BCD_00, BCD_01, BCD_00, BCD_01, BCD_00};

	always_comb begin
		for (int i = 0; i < TIME_COUNT; i++) begin
			wrap[i] = val[i] >= top[i];
		end
		// 12 hour mode: day rolls at 11 pm to 12 am
		if (mode_12h) begin
			wrap[T_HOUR] = (hour12 == BCD_11) && pm;
		end
		inc[T_SEC] = tick_apply;
		inc[T_MIN] = inc[T_SEC] & wrap[T_SEC];
		inc[T_HOUR] = inc[T_MIN] & wrap[T_MIN];
		inc[T_DAY] = inc[T_HOUR] & wrap[T_HOUR];
		inc[T_WDAY] = inc[T_DAY];
		inc[T_MON] = inc[T_DAY] & wrap[T_DAY];
		inc[T_YEAR] = inc[T_MON] & wrap[T_MON];
	end

	always_comb begin
		tm_nxt = tm_r;
		for (int i = 0; i < TIME_COUNT; i++) begin
			if (inc[i]) begin
				tm_nxt[i] = (tm_r[i] & ~REG_MASK[i + ADDR_SECONDS])
					| bcd_inc(val[i], top[i], low[i]); // see [R10]
			end
		end
		if (inc[T_HOUR] && mode_12h) begin
			if (hour12 == BCD_11) begin
				tm_nxt[T_HOUR] = BCD_12 | {2'b00, ~pm, 5'h00};
			end else if (hour12 >= BCD_12) begin
				tm_nxt[T_HOUR] = BCD_01 | {2'b00, pm, 5'h00};
			end else begin
				tm_nxt[T_HOUR] = bcd_inc(hour12, BCD_12, BCD_01) | {2'b00, pm, 5'h00};
			end
		end
		if (xtal_stopped) begin
			tm_nxt[T_SEC][OS_BIT] = 1'b1;
		end
		// writes land only during an access, when no tick is applied
		if (wr_req.en && addr_is_time) begin
			tm_nxt[tidx] = wr_req.data;
			if (tidx == 3'(T_SEC) && xtal_stopped) begin
				tm_nxt[T_SEC][OS_BIT] = 1'b1;
			end
		end
	end

	for (genvar i = 0; i < TIME_COUNT; i++) begin : g_time
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				tm_r[i] <= REG_RESET[i + ADDR_SECONDS]; // see [R18]
			end else begin
				tm_r[i] <= tm_nxt[i];
			end
		end
	end
endmodule // rtc_register_access

// ==== tb/rtc_access_chk.sv ====
// port-level checker for the rtc register block
// assumes only the top module ports, one clock domain
`timescale 1ns/1ps
module rtc_access_chk
	import rtc_pkg::*;
#(
	parameter int PRESCALE_BITS = PRESCALE_BITS_DEF,
	parameter int XTAL_STOP_CYCLES = XTAL_STOP_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic crystal_in,
	input wire logic crystal_out,
	input wire logic clock_output_enable,
	input wire logic clock_output,
	input wire logic ce,
	input wire logic scl,
	input wire logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence ce_idle;
		!ce [*6];
	endsequence
	sequence xtal_steady;
		$stable(crystal_in) [*5];
	endsequence
	sequence enable_low;
		!clock_output_enable [*5];
	endsequence
	idle_no_drive_a: assert property (ce_idle |-> !sdio_oe)
		else $error("data line driven while chip enable idle");
	drop_release_a: assert property ($fell(ce) |-> ##[1:8] !sdio_oe)
		else $error("data line not released after chip enable drop");
	oe_hold_a: assert property ($fell(sdio_oe) |-> !$past(ce, 2))
		else $error("data line released inside a frame");
	oe_start_a: assert property ($rose(sdio_oe) |-> ce && $past(ce, 4))
		else $error("data line driven without a frame");
	bit_change_a: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_out)
		|-> !scl && !$past(scl, 2))
		else $error("data bit changed outside serial clock low");
	clock_output_off_a: assert property (enable_low |-> !clock_output)
		else $error("clock output active with enable low");
	xtal_inv_a: assert property (xtal_steady |-> crystal_out == !crystal_in)
		else $error("crystal output not inverse of input");
	reset_out_a: assert property ($rose(rstn)
		|-> !sdio_oe && !sdio_out && !clock_output && !crystal_out)
		else $error("outputs not at reset level");
endmodule // rtc_access_chk

bind rtc_register_access rtc_access_chk #(
	.PRESCALE_BITS(PRESCALE_BITS),
	.XTAL_STOP_CYCLES(XTAL_STOP_CYCLES)
) chk (
	.clk(clk),
	.rstn(rstn),
	.crystal_in(crystal_in),
	.crystal_out(crystal_out),
	.clock_output_enable(clock_output_enable),
	.clock_output(clock_output),
	.ce(ce),
	.scl(scl),
	.sdio_in(sdio_in),
	.sdio_out(sdio_out),
	.sdio_oe(sdio_oe)
);

// ==== tb/host_model.sv ====
// host serial master model: chip enable, serial clock, shared data line
// assumes the bench resolves the data wire and returns it on sdio_wire
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	input wire logic sdio_wire,
	output logic ce,
	output logic scl,
	output logic sdio_drv,
	output logic sdio_drv_en
);
	logic [7:0] wbuf [40];
	logic [7:0] rbuf [40];
	initial begin
		ce = 1'b0;
		scl = 1'b0;
		sdio_drv = 1'b0;
		sdio_drv_en = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// 6 clk each phase stays above the 4 clk minimum
	task automatic bit_cyc(input logic drv, input logic b, output logic got);
		sdio_drv_en = drv;
		sdio_drv = b;
		tick(6);
		scl = 1'b1;
		got = sdio_wire;
		tick(6);
		scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] cmd, input int n);
		logic g;
		tick(1);
		ce = 1'b1;
		tick(6);
		for (int i = 7; i >= 0; i--) bit_cyc(1'b1, cmd[i], g);
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				bit_cyc(!cmd[7], wbuf[k][i], g);
				rbuf[k][i] = g;
			end
		end
		tick(6);
		sdio_drv_en = 1'b0;
		ce = 1'b0;
		tick(8);
	endtask
endmodule // host_model

// ==== tb/testbench.sv ====
// self-checking bench for the rtc register block with a host model
// assumes a shortened prescaler and a free-running crystal wave
`timescale 1ns/1ps
module testbench;
	import rtc_pkg::*;
	localparam logic [7:0] ROWS [8][3] = '{'{8'h02, 8'hff, 8'hff},
		'{8'h03, 8'ha5, 8'ha5}, '{8'h0d, 8'hff, 8'hbf}, '{8'h0e, 8'hff, 8'hbf},
		'{8'h0f, 8'hff, 8'h87}, '{8'h10, 8'h3c, 8'h3c}, '{8'h11, 8'hff, 8'h1f},
		'{8'h12, 8'h55, 8'h00}};
	localparam logic [7:0] CARRY [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
	localparam logic [7:0] SET_TIME [7] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99};
	// tap 6 is watched over three windows, the others over one
	localparam int EXP_RISES [8] = '{64, 32, 16, 8, 4, 2, 3, 0};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic crystal_in = 1'b0;
	logic clock_output_enable = 1'b1;
	logic float_r = 1'b0;
	logic crystal_out, clock_output, sdio_out, sdio_oe, sdio_in;
	logic ce, scl, sdio_drv, sdio_drv_en;
	int errors = 0;
	int tests_run = 0;
	int rises = 0;
	always #10 clk = ~clk;
	// 805 ns half period keeps the crystal out of step with clk
	always #805 crystal_in = ~crystal_in;
	// undriven wire toggles so a stale bit cannot pass
	always @(posedge clk) float_r <= ~float_r;
	assign sdio_in = sdio_oe ? sdio_out : (sdio_drv_en ? sdio_drv : float_r);
	always @(posedge clock_output) rises++;
	// six bits is the shortest divider that keeps the 1 Hz tap apart from the 1.024 khz tap
	rtc_register_access #(.PRESCALE_BITS(6), .XTAL_STOP_CYCLES(200)) dut (
		.clk(clk),
		.rstn(rstn),
		.crystal_in(crystal_in),
		.crystal_out(crystal_out),
		.clock_output_enable(clock_output_enable),
		.clock_output(clock_output),
		.ce(ce),
		.scl(scl),
		.sdio_in(sdio_in),
		.sdio_out(sdio_out),
		.sdio_oe(sdio_oe)
	);
	host_model host (
		.clk(clk),
		.sdio_wire(sdio_in),
		.ce(ce),
		.scl(scl),
		.sdio_drv(sdio_drv),
		.sdio_drv_en(sdio_drv_en)
	);
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic check_cnt(input int got, input int exp);
		int tol;
		tol = (exp > 0) ? 1 : 0;
		tests_run++;
		if (got > exp + tol || got < exp - tol) begin
			errors++;
			$display("ERROR %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.wbuf[0] = d;
		host.xfer(a, 1);
	endtask
	task automatic rd(input logic [7:0] a, input int n);
		host.xfer(8'h80 | a, n);
	endtask
	task automatic wrap_up;
		$display("checks %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (5) @(posedge clk);
		rd(8'h00, 18);
		for (int i = 0; i < REG_COUNT; i++) check8(host.rbuf[i], REG_RESET[i]);
		foreach (ROWS[r]) begin
			wr(ROWS[r][0], ROWS[r][1]);
			rd(ROWS[r][0], 1);
			check8(host.rbuf[0], ROWS[r][2]);
		end
		rd(8'h11, 2);
		check8(host.rbuf[0], 8'h1f);
		check8(host.rbuf[1], 8'h00);
		// last day of year, one tick from a full carry
		for (int i = 0; i < TIME_COUNT; i++) host.wbuf[i] = SET_TIME[i];
		host.xfer(8'h04, 7);
		// the seconds write restarts the divider; one tick (5152 clk) lands here
		repeat (5000) @(posedge clk);
		rd(8'h04, 7);
		for (int i = 0; i < TIME_COUNT; i++) check8(host.rbuf[i], CARRY[i]);
		wr(8'h04, 8'h10);
		// the next tick falls inside the long read, before byte 18 is loaded
		repeat (4000) @(posedge clk);
		rd(8'h04, 30);
		check8(host.rbuf[0], 8'h10);
		check8(host.rbuf[18], 8'h10);
		rd(8'h04, 1);
		check8(host.rbuf[0], 8'h11);
		for (int c = 0; c < CLOCK_OUTPUT_TAPS; c++) begin
			wr(8'h01, 8'(c));
			rises = 0;
			repeat ((c == 6) ? 15456 : 5152) @(posedge clk);
			check_cnt(rises, EXP_RISES[c]);
		end
		wr(8'h01, 8'h00);
		clock_output_enable = 1'b0;
		repeat (10) @(posedge clk);
		rises = 0;
		repeat (2000) @(posedge clk);
		check_cnt(rises, 0);
		#1 clock_output_enable = 1'b1;
		repeat (10) @(posedge clk);
		rises = 0;
		repeat (2415) @(posedge clk);
		check_cnt(rises, 30);
		#1 rstn = 1'b0;
		repeat (2) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (5) @(posedge clk);
		rd(8'h03, 2);
		check8(host.rbuf[0], 8'h00);
		check8(host.rbuf[1], 8'h80);
		wrap_up();
	end
endmodule // testbench
